// *** mde_bus_host.sv ***
// Bus transceiver loopback with host serial source and sink
module mde_bus_host
  import mde_pkg::*;
(
  input wire logic clk,
  input wire logic clear,
  input wire logic uni_mode,
  input wire logic [31:0] tx_word,
  input wire logic bip_one_out_n,
  input wire logic bip_zero_out_n,
  input wire logic send_data,
  input wire logic enc_shift_clk,
  input wire logic dec_shift_clk,
  input wire logic take_data,
  input wire logic ser_data_out,
  output logic bip_one_in,
  output logic bip_zero_in,
  output logic uni_data_in,
  output logic ser_data_in,
  output logic [27:0] rx_word,
  output logic [5:0] rx_n
);
  logic esc_q = 1'h0;
  logic dsc_q = 1'h0;
  logic idle_tog = 1'h0;
  int idx = 0;
  // Receiver pair, or zero high, one low and noninverted level
  assign bip_one_in = uni_mode ? 1'h0 : ~bip_one_out_n;
  assign bip_zero_in = uni_mode ? 1'h1 : ~bip_zero_out_n;
  assign uni_data_in = uni_mode ? bip_zero_out_n : 1'h0;
  // One bit per shift period while requested, changing when released
  assign ser_data_in = send_data ? tx_word[idx] : idle_tog;
  always_ff @(posedge clk) begin
    esc_q <= enc_shift_clk;
    dsc_q <= dec_shift_clk;
    idle_tog <= ~idle_tog;
    if (!send_data) begin
      idx <= 0;
    end else if (enc_shift_clk && !esc_q) begin
      idx <= idx + 1;
    end
    if (clear) begin
      rx_n <= 6'h0;
      rx_word <= 28'h0;
    end else if (dec_shift_clk && !dsc_q && take_data) begin
      rx_word[rx_n] <= ser_data_out;
      rx_n <= rx_n + 6'h1;
    end
  end
endmodule

// *** mde_codec.sv ***
// Manchester II encoder, decoder and decoded-bit FIFO
module mde_fifo #(
  parameter int W = 1,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic wr, rd;

  assign in_ready = cnt_r != CW'(D);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];

  always_comb begin
    wr = in_valid & in_ready;
    rd = out_valid & out_ready;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (wr) begin
      wp_nxt = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
    end
    if (rd) begin
      rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
    end
    if (wr && !rd) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (rd && !wr) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    if (flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_r] <= in_data;
    end
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// What this block does
// - Encoder clock divided by six drives a dedicated output.
// - Encode starts on enable at shift clock fall; lasts K plus four periods.
// - First shift clock rise samples sync type: high command, low data.
// - Data request output stays high exactly K shift clock periods.
// - One parity bit follows data; odd when parity input high.
// - Line outputs active low; inhibit low forces both high.
// - Master reset then a send clock rise aborts and readies encoder.
// - Master reset clears both divide-by-two counters.
// - Decoder clock twelve times bit rate; shift clock is it over twelve.
// - Select inputs route external double-rate clock and data to decoder.
// - Resync on every transition when selected, else mid-bit only.
// - Half bit six clocks, full bit twelve, sync span eighteen.
// - Output starts only after valid sync and two valid bits.
// - Command or data sync indicator stays high for K periods.
// - Decoded NRZ bits stable on decoder shift clock rising edge.
// - Parity checked after K bits: even when input high, else odd.
// - Valid word only without Manchester or parity errors.
// - Data window during output; companion free runs, locks to data.
// - Decoder reset at shift clock rise aborts word, hunts again.
// - Five count inputs set frame length for encoder and decoder.
// - Payload is two to twenty-eight data bits.
// - Frame spans data bits plus four bit periods.
module mde_codec
  import mde_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic MASTER_RESET,
  input wire logic FRAME_LEN_B0,
  input wire logic FRAME_LEN_B1,
  input wire logic FRAME_LEN_B2,
  input wire logic FRAME_LEN_B3,
  input wire logic FRAME_LEN_B4,
  input wire logic ENC_CLK,
  output logic DIV6_OUT,
  input wire logic SEND_CLK_IN,
  output logic ENC_SHIFT_CLK,
  input wire logic ENC_ENABLE,
  input wire logic SYNC_SEL,
  input wire logic ENC_PAR_SEL,
  input wire logic SER_DATA_IN,
  output logic SEND_DATA,
  input wire logic OUTPUT_INHIBIT_N,
  output logic BIP_ONE_OUT_N,
  output logic BIP_ZERO_OUT_N,
  input wire logic DEC_CLK,
  input wire logic SYNC_CLK,
  input wire logic SYNC_CLK_SEL,
  input wire logic SYNC_DATA,
  input wire logic SYNC_DATA_SEL,
  input wire logic BIP_ONE_IN,
  input wire logic BIP_ZERO_IN,
  input wire logic UNI_DATA_IN,
  input wire logic TRANS_SEL,
  input wire logic DEC_PAR_SEL,
  input wire logic DEC_RESET,
  output logic DEC_SHIFT_CLK,
  output logic SER_DATA_OUT,
  output logic TAKE_DATA,
  output logic TAKE_DATA_FREE,
  output logic CMD_SYNC,
  output logic DATA_SYNC,
  output logic VALID_WORD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // Input edge detection
  logic sc_q_r, ec_q_r, dc_q_r, yc_q_r;
  logic send_rise, enc_rise;
  always_ff @(posedge CLK) begin
    if (RST) begin
      sc_q_r <= 1'b0;
      ec_q_r <= 1'b0;
      dc_q_r <= 1'b0;
      yc_q_r <= 1'b0;
    end else begin
      sc_q_r <= SEND_CLK_IN;
      ec_q_r <= ENC_CLK;
      dc_q_r <= DEC_CLK;
      yc_q_r <= SYNC_CLK;
    end
  end
  assign send_rise = SEND_CLK_IN & ~sc_q_r;
  assign enc_rise = ENC_CLK & ~ec_q_r;

  // Frame length
  logic [4:0] code, k_bits;
  logic [5:0] last_slot;
  always_comb begin
    code = {FRAME_LEN_B4, FRAME_LEN_B3, FRAME_LEN_B2, FRAME_LEN_B1, FRAME_LEN_B0};
    k_bits = (code < 5'(FRAME_CODE_MIN)) ? 5'(DATA_MIN) : code - 5'(FRAME_CODE_OFS);
    last_slot = {k_bits, 1'b0} + 6'(SYNC_SLOTS + 1);
  end

  // Divide-by-six auxiliary counter
  logic [1:0] e6_r, e6_nxt;
  logic div6_r, div6_nxt;
  always_comb begin
    e6_nxt = e6_r;
    div6_nxt = div6_r;
    if (enc_rise) begin
      if (e6_r == 2'(DIV6_HALF - 1)) begin
        e6_nxt = '0;
        div6_nxt = ~div6_r;
      end else begin
        e6_nxt = e6_r + 1'b1;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      e6_r <= '0;
      div6_r <= 1'b0;
    end else begin
      e6_r <= e6_nxt;
      div6_r <= div6_nxt;
    end
  end
  assign DIV6_OUT = div6_r;
  AST_DIV6: assert property ($changed(div6_r) |-> $past(e6_r) == 2'd2)
    else $error("Divider output toggled off count");

  // Encoder
  mde_enc_e enc_st_r, enc_st_nxt;
  logic [5:0] slot_r, slot_nxt, s;
  logic esc_r, esc_nxt, csync_r, csync_nxt, par_r, par_nxt, bit_r, bit_nxt;
  logic lvl_r, lvl_nxt, act_r, act_nxt, sd_r, sd_nxt, mrp_r, mrp_nxt;
  logic one_n_r, one_n_nxt, zero_n_r, zero_n_nxt;
  always_comb begin
    enc_st_nxt = enc_st_r;
    slot_nxt = slot_r;
    esc_nxt = esc_r;
    csync_nxt = csync_r;
    par_nxt = par_r;
    bit_nxt = bit_r;
    lvl_nxt = lvl_r;
    act_nxt = act_r;
    sd_nxt = sd_r;
    mrp_nxt = mrp_r | MASTER_RESET;
    s = slot_r + 1'b1;
    if (send_rise && (mrp_r || MASTER_RESET)) begin
      esc_nxt = 1'b0;
      enc_st_nxt = ENC_IDLE;
      slot_nxt = '0;
      act_nxt = 1'b0;
      sd_nxt = 1'b0;
      mrp_nxt = MASTER_RESET;
    end else if (send_rise) begin
      esc_nxt = ~esc_r;
      unique case (enc_st_r)
        ENC_IDLE: begin
          if (esc_r && ENC_ENABLE) begin
            enc_st_nxt = ENC_ARM;
          end
        end
        ENC_ARM: begin
          enc_st_nxt = ENC_SEND;
          slot_nxt = '0;
          csync_nxt = SYNC_SEL;
          par_nxt = ENC_PAR_SEL;
          act_nxt = 1'b1;
          lvl_nxt = SYNC_SEL;
        end
        ENC_SEND: begin
          if (slot_r == last_slot) begin
            enc_st_nxt = ENC_IDLE;
            act_nxt = 1'b0;
          end else begin
            slot_nxt = s;
            sd_nxt = (s >= 6'(SYNC_SLOTS - 1)) && (s < last_slot - 6'd2);
            if (s < 6'(SYNC_SLOTS)) begin
              lvl_nxt = (s < 6'(SYNC_HALF_SLOTS)) ? csync_r : ~csync_r;
            end else if (!s[0] && s < last_slot - 6'd1) begin
              bit_nxt = SER_DATA_IN;
              par_nxt = par_r ^ SER_DATA_IN;
              lvl_nxt = SER_DATA_IN;
            end else if (!s[0]) begin
              bit_nxt = par_r;
              lvl_nxt = par_r;
            end else begin
              lvl_nxt = ~bit_r;
            end
          end
        end
      endcase
    end
    one_n_nxt = ~(act_r & lvl_r & OUTPUT_INHIBIT_N);
    zero_n_nxt = ~(act_r & ~lvl_r & OUTPUT_INHIBIT_N);
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      enc_st_r <= ENC_IDLE;
      slot_r <= '0;
      esc_r <= 1'b0;
      csync_r <= 1'b0;
      par_r <= 1'b0;
      bit_r <= 1'b0;
      lvl_r <= 1'b0;
      act_r <= 1'b0;
      sd_r <= 1'b0;
      mrp_r <= 1'b0;
      one_n_r <= 1'b1;
      zero_n_r <= 1'b1;
    end else begin
      enc_st_r <= enc_st_nxt;
      slot_r <= slot_nxt;
      esc_r <= esc_nxt;
      csync_r <= csync_nxt;
      par_r <= par_nxt;
      bit_r <= bit_nxt;
      lvl_r <= lvl_nxt;
      act_r <= act_nxt;
      sd_r <= sd_nxt;
      mrp_r <= mrp_nxt;
      one_n_r <= one_n_nxt;
      zero_n_r <= zero_n_nxt;
    end
  end
  assign ENC_SHIFT_CLK = esc_r;
  assign SEND_DATA = sd_r;
  assign BIP_ONE_OUT_N = one_n_r;
  assign BIP_ZERO_OUT_N = zero_n_r;
  AST_INHIBIT: assert property (!OUTPUT_INHIBIT_N |=> BIP_ONE_OUT_N && BIP_ZERO_OUT_N)
    else $error("Inhibit did not force line outputs high");
  AST_NOT_BOTH: assert property (BIP_ONE_OUT_N || BIP_ZERO_OUT_N)
    else $error("Both line outputs active");
  AST_SEND_DATA: assert property (SEND_DATA |-> enc_st_r == ENC_SEND)
    else $error("Data request outside encode cycle");
  AST_ENC_ABORT: assert property (MASTER_RESET && send_rise |=> enc_st_r == ENC_IDLE && !esc_r)
    else $error("Master reset did not abort encoder");
  AST_SLOT: assert property (enc_st_r == ENC_SEND |-> slot_r <= last_slot)
    else $error("Encode cycle overran frame");

  // Decoder receive side
  logic [4:0] step, ph_sum, ph_r, ph_nxt, bidx_r, bidx_nxt;
  logic [5:0] runl_r, runl_nxt;
  logic [6:0] span;
  logic tick, din, trans, wrap, samp_a, samp_b, sh_rise, kill, quiet;
  mde_rx_e rx_st_r, rx_st_nxt;
  logic din_r, din_nxt, typ_r, typ_nxt, a_r, a_nxt, w1_r, w1_nxt, pacc_r, pacc_nxt;
  logic done_r, done_nxt, ok_r, ok_nxt, err_r, err_nxt, dsc_r, dsc_nxt;
  logic push, push_rdy, pop, pop_vld, pop_bit, flush, out_clr, bad;
  logic set_done, set_ok, set_err;
  always_comb begin
    if (SYNC_CLK_SEL) begin
      step = (SYNC_CLK & ~yc_q_r) ? 5'(SYNC_CLK_STEP) : 5'd0;
    end else begin
      step = (DEC_CLK & ~dc_q_r) ? 5'(DEC_CLK_STEP) : 5'd0;
    end
    tick = step != 5'd0;
    din = SYNC_DATA_SEL ? SYNC_DATA : (BIP_ONE_IN | (UNI_DATA_IN & BIP_ZERO_IN));
    // Bus neither positive nor negative: run starts when it wakes
    quiet = !SYNC_DATA_SEL && !BIP_ONE_IN && !BIP_ZERO_IN;
    trans = tick && (din != din_r);
    span = {1'b0, runl_r} + {2'b0, step};
    ph_sum = ph_r + step;
    wrap = ph_sum >= 5'(BIT_TICKS);
    ph_nxt = wrap ? ph_sum - 5'(BIT_TICKS) : ph_sum;
    samp_a = tick && ph_r < 5'(SAMPLE_A) && ph_sum >= 5'(SAMPLE_A);
    samp_b = tick && ph_r < 5'(SAMPLE_B) && ph_sum >= 5'(SAMPLE_B);
    rx_st_nxt = rx_st_r;
    din_nxt = tick ? din : din_r;
    runl_nxt = runl_r;
    if (tick) begin
      runl_nxt = (trans || quiet) ? 6'd0 : (span > 7'd63 ? 6'd63 : span[5:0]);
    end
    typ_nxt = typ_r;
    a_nxt = samp_a ? din : a_r;
    w1_nxt = w1_r;
    bidx_nxt = bidx_r;
    pacc_nxt = pacc_r;
    push = 1'b0;
    bad = 1'b0;
    set_done = 1'b0;
    set_ok = 1'b0;
    set_err = 1'b0;
    unique case (rx_st_r)
      RX_HUNT: begin
        if (trans && span >= 7'(SYNC_TICKS - SPAN_TOL) && span <= 7'(SYNC_TICKS + SPAN_TOL)) begin
          rx_st_nxt = RX_SYNC2;
          typ_nxt = din_r;
          ph_nxt = 5'(HALF_TICKS);
          w1_nxt = 1'b0;
        end
      end
      RX_SYNC2: begin
        if ((samp_a || samp_b) && din == typ_r) begin
          rx_st_nxt = RX_HUNT;
        end else if (wrap && w1_r) begin
          rx_st_nxt = RX_BITS;
          bidx_nxt = '0;
          pacc_nxt = 1'b0;
        end else if (wrap) begin
          w1_nxt = 1'b1;
        end
      end
      RX_BITS: begin
        if (trans && ph_nxt >= 5'(SAMPLE_A) && ph_nxt <= 5'(SAMPLE_B)) begin
          ph_nxt = 5'(HALF_TICKS);
        end else if (trans && TRANS_SEL) begin
          ph_nxt = '0;
        end
        if (samp_b) begin
          if (din == a_r) begin
            bad = 1'b1;
          end else if (bidx_r < k_bits) begin
            push = 1'b1;
            bad = !push_rdy;
            pacc_nxt = pacc_r ^ a_r;
            bidx_nxt = bidx_r + 1'b1;
          end else begin
            rx_st_nxt = RX_HUNT;
            set_done = 1'b1;
            set_ok = (pacc_r ^ a_r) == ~DEC_PAR_SEL;
          end
        end
        if (bad) begin
          rx_st_nxt = RX_HUNT;
          set_err = 1'b1;
        end
      end
    endcase
    dsc_nxt = ph_nxt >= 5'(HALF_TICKS);
    sh_rise = dsc_nxt & ~dsc_r;
    kill = MASTER_RESET | (DEC_RESET & sh_rise);
    if (kill) begin
      rx_st_nxt = RX_HUNT;
      set_err = 1'b0;
      set_done = 1'b0;
    end
    if (MASTER_RESET) begin
      ph_nxt = '0;
      dsc_nxt = 1'b0;
    end
    done_nxt = set_done | (done_r & ~out_clr);
    ok_nxt = set_ok | (ok_r & ~out_clr);
    err_nxt = set_err | (err_r & ~out_clr);
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_st_r <= RX_HUNT;
      ph_r <= '0;
      runl_r <= '0;
      din_r <= 1'b0;
      typ_r <= 1'b0;
      a_r <= 1'b0;
      w1_r <= 1'b0;
      bidx_r <= '0;
      pacc_r <= 1'b0;
      done_r <= 1'b0;
      ok_r <= 1'b0;
      err_r <= 1'b0;
      dsc_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      ph_r <= ph_nxt;
      runl_r <= runl_nxt;
      din_r <= din_nxt;
      typ_r <= typ_nxt;
      a_r <= a_nxt;
      w1_r <= w1_nxt;
      bidx_r <= bidx_nxt;
      pacc_r <= pacc_nxt;
      done_r <= done_nxt;
      ok_r <= ok_nxt;
      err_r <= err_nxt;
      dsc_r <= dsc_nxt;
    end
  end
  assign DEC_SHIFT_CLK = dsc_r;

  mde_fifo #(.W(1), .D(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .flush(flush),
    .in_valid(push),
    .in_ready(push_rdy),
    .in_data(a_r),
    .out_valid(pop_vld),
    .out_ready(pop),
    .out_data(pop_bit)
  );

  // Decoder output stage
  logic out_act_r, out_act_nxt;
  logic [4:0] ocnt_r, ocnt_nxt;
  mde_dout_s dout_r, dout_nxt;
  logic owrap;
  always_comb begin
    owrap = tick && wrap;
    out_act_nxt = out_act_r;
    ocnt_nxt = ocnt_r;
    dout_nxt = dout_r;
    pop = 1'b0;
    out_clr = 1'b0;
    flush = kill || (set_err && !out_act_r);
    if (owrap && dout_r.valid) begin
      dout_nxt.valid = 1'b0;
    end
    if (kill) begin
      out_act_nxt = 1'b0;
      dout_nxt.valid = 1'b0;
      out_clr = 1'b1;
    end else if (owrap && !out_act_r) begin
      if (rx_st_r == RX_BITS && bidx_r == 5'(START_BITS) && pop_vld) begin
        out_act_nxt = 1'b1;
        out_clr = 1'b1;
        pop = 1'b1;
        dout_nxt.ser = pop_bit;
        dout_nxt.valid = 1'b0;
        ocnt_nxt = 5'd1;
      end
    end else if (owrap) begin
      if (ocnt_r < k_bits && pop_vld) begin
        pop = 1'b1;
        dout_nxt.ser = pop_bit;
        ocnt_nxt = ocnt_r + 1'b1;
      end else begin
        out_act_nxt = 1'b0;
        out_clr = 1'b1;
        dout_nxt.valid = (ocnt_r == k_bits) && done_r && ok_r && !err_r;
      end
    end
    dout_nxt.take = out_act_nxt;
    dout_nxt.cmd = out_act_nxt && typ_r;
    dout_nxt.dat = out_act_nxt && !typ_r;
    dout_nxt.free = out_act_nxt || (rx_st_nxt == RX_HUNT && !dsc_nxt);
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_act_r <= 1'b0;
      ocnt_r <= '0;
      dout_r <= '0;
    end else begin
      out_act_r <= out_act_nxt;
      ocnt_r <= ocnt_nxt;
      dout_r <= dout_nxt;
    end
  end
  assign TAKE_DATA = dout_r.take;
  assign CMD_SYNC = dout_r.cmd;
  assign DATA_SYNC = dout_r.dat;
  assign SER_DATA_OUT = dout_r.ser;
  assign VALID_WORD = dout_r.valid;
  assign TAKE_DATA_FREE = dout_r.free;

  AST_SYNC_EXCL: assert property (!(CMD_SYNC && DATA_SYNC))
    else $error("Both sync indicators high");
  AST_TAKE: assert property (TAKE_DATA == (CMD_SYNC || DATA_SYNC))
    else $error("Data window and sync indicator disagree");
  AST_VALID: assert property ($rose(VALID_WORD) |-> $past(done_r && ok_r && !err_r))
    else $error("Valid word without clean reception");
  AST_DEC_RST: assert property (DEC_RESET && sh_rise |=> !TAKE_DATA && rx_st_r == RX_HUNT)
    else $error("Decoder reset did not abort word");
  AST_START: assert property ($rose(out_act_r) |-> $past(bidx_r) == 5'd2)
    else $error("Output cycle started early");
endmodule

// *** mde_pkg.sv ***
// Shared constants, states and carriers for the Manchester codec
package mde_pkg;
  localparam int BIT_TICKS = 12;
  localparam int HALF_TICKS = 6;
  localparam int SYNC_TICKS = 18;
  localparam int SPAN_TOL = 3;
  localparam int SAMPLE_A = 3;
  localparam int SAMPLE_B = 9;
  localparam int DEC_CLK_STEP = 1;
  localparam int SYNC_CLK_STEP = 6;
  localparam int DIV6_HALF = 3;
  localparam int FRAME_CODE_OFS = 3;
  localparam int FRAME_CODE_MIN = 5;
  localparam int DATA_MIN = 2;
  localparam int DATA_MAX = 28;
  localparam int SYNC_SLOTS = 6;
  localparam int SYNC_HALF_SLOTS = 3;
  localparam int START_BITS = 2;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    ENC_IDLE = 3'b001,
    ENC_ARM = 3'b010,
    ENC_SEND = 3'b100
  } mde_enc_e;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_SYNC2 = 3'b010,
    RX_BITS = 3'b100
  } mde_rx_e;

  typedef struct packed {
    logic take;
    logic cmd;
    logic dat;
    logic ser;
    logic valid;
    logic free;
  } mde_dout_s;
endpackage

// *** tb_top.sv ***
// Self-checking bench for the Manchester codec
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mde_pkg::*;
  localparam int TICK = 6;
  logic clk = 1'h0, rst = 1'h1, mreset = 1'h0, send_clk = 1'h0, dec_clk = 1'h0;
  logic enable = 1'h0, sync_sel = 1'h0, enc_par = 1'h0, inhibit_n = 1'h1, clear = 1'h1;
  logic trans_sel = 1'h0, dec_par = 1'h1, dec_reset = 1'h0, uni_mode = 1'h0;
  logic [4:0] code = 5'h05;
  logic [31:0] tx_word = 32'h0;
  logic div6, esc, ser_in, send_data, one_n, zero_n, one_in, zero_in, uni_in;
  logic dsc, ser_out, take, take_free, cmd, dat, valid;
  logic saw_valid = 1'h0, saw_cmd = 1'h0, saw_dat = 1'h0;
  logic [27:0] rx_word;
  logic [5:0] rx_n;
  int failures = 0, n_tests = 0, cyc = 0, sync_len = 0;

  mde_codec u_dut (
    .CLK(clk), .RST(rst), .MASTER_RESET(mreset),
    .FRAME_LEN_B0(code[0]), .FRAME_LEN_B1(code[1]), .FRAME_LEN_B2(code[2]),
    .FRAME_LEN_B3(code[3]), .FRAME_LEN_B4(code[4]), .ENC_CLK(dec_clk), .DIV6_OUT(div6),
    .SEND_CLK_IN(send_clk), .ENC_SHIFT_CLK(esc), .ENC_ENABLE(enable), .SYNC_SEL(sync_sel),
    .ENC_PAR_SEL(enc_par), .SER_DATA_IN(ser_in), .SEND_DATA(send_data),
    .OUTPUT_INHIBIT_N(inhibit_n), .BIP_ONE_OUT_N(one_n), .BIP_ZERO_OUT_N(zero_n),
    .DEC_CLK(dec_clk), .SYNC_CLK(1'h1), .SYNC_CLK_SEL(1'h0), .SYNC_DATA(1'h1),
    .SYNC_DATA_SEL(1'h0), .BIP_ONE_IN(one_in), .BIP_ZERO_IN(zero_in), .UNI_DATA_IN(uni_in),
    .TRANS_SEL(trans_sel), .DEC_PAR_SEL(dec_par), .DEC_RESET(dec_reset),
    .DEC_SHIFT_CLK(dsc), .SER_DATA_OUT(ser_out), .TAKE_DATA(take),
    .TAKE_DATA_FREE(take_free), .CMD_SYNC(cmd), .DATA_SYNC(dat), .VALID_WORD(valid)
  );
  mde_bus_host u_bus (
    .clk(clk), .clear(clear), .uni_mode(uni_mode), .tx_word(tx_word),
    .bip_one_out_n(one_n), .bip_zero_out_n(zero_n), .send_data(send_data),
    .enc_shift_clk(esc), .dec_shift_clk(dsc), .take_data(take), .ser_data_out(ser_out),
    .bip_one_in(one_in), .bip_zero_in(zero_in), .uni_data_in(uni_in),
    .ser_data_in(ser_in), .rx_word(rx_word), .rx_n(rx_n)
  );

  initial forever #50 clk = ~clk;
  // Decoder clock twelve and send clock two times the bit rate
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) dec_clk <= ~dec_clk;
    if (cyc % 18 == 17) send_clk <= ~send_clk;
  end
  // Decoder indicator monitor
  always @(posedge clk) begin
    if (clear) begin
      saw_valid <= 1'h0;
      saw_cmd <= 1'h0;
      saw_dat <= 1'h0;
      sync_len <= 0;
    end else begin
      if (valid === 1'h1) saw_valid <= 1'h1;
      if (cmd === 1'h1) saw_cmd <= 1'h1;
      if (dat === 1'h1) saw_dat <= 1'h1;
      if ((cmd | dat) === 1'h1) sync_len <= sync_len + 1;
    end
  end

  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      failures++;
      $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return send_clk;
      1: return take;
      2: return div6;
      3: return dsc;
      4: return esc;
      default: return send_data;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pick(s) !== lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        failures++;
        $display("Error at %0t: wait on signal %0d timed out", $time, s);
        tally_and_finish();
      end
    end
  endtask
  task automatic chk_period(input int s, input int exp);
    int t0;
    wait_for(s, 1'h0, 200);
    wait_for(s, 1'h1, 200);
    t0 = cyc;
    wait_for(s, 1'h0, 200);
    wait_for(s, 1'h1, 200);
    chk_num(cyc - t0, exp);
  endtask
  function automatic logic exp_lvl(input int s, input int k, input logic sy,
      input logic [31:0] d, input logic p);
    logic b;
    if (s < 6) return (s < 3) ? sy : ~sy;
    b = (s < 6 + 2 * k) ? d[(s - 6) / 2] : p;
    return (s % 2 == 0) ? b : ~b;
  endfunction
  task automatic setup(input int k, input logic sy, input logic [31:0] d);
    code = 5'(k + FRAME_CODE_OFS);
    sync_sel = sy;
    tx_word = d;
    clear = 1'h1;
    @(negedge clk);
    clear = 1'h0;
  endtask
  task automatic start_enc(input int k, input logic sy, input logic [31:0] d);
    setup(k, sy, d);
    enable = 1'h1;
    wait_for(5, 1'h1, 1600);
    enable = 1'h0;
  endtask

  // Full word through encoder, line and decoder
  task automatic send_word(input int k, input logic sy, input logic ep, input logic dp,
      input logic [31:0] d);
    logic [31:0] dm;
    logic p, e;
    int s, n, sd;
    dm = d & ((32'h1 << k) - 32'h1);
    p = ep ? ~^dm : ^dm;
    enc_par = ep;
    dec_par = dp;
    setup(k, sy, d);
    enable = 1'h1;
    s = 0;
    sd = 0;
    for (n = 0; n < 120 && s < 2 * k + 9; n++) begin
      wait_for(0, 1'h0, 40);
      wait_for(0, 1'h1, 40);
      repeat (18) @(negedge clk);
      if (s > 0 || (one_n & zero_n) !== 1'h1) begin
        enable = 1'h0;
        e = exp_lvl(s, k, sy, dm, p);
        if (s == 2 * k + 8) chk_vec({one_n, zero_n}, 2'h3);
        else chk_vec({one_n, zero_n}, {~e, e});
        sd += int'(send_data === 1'h1);
        s++;
      end
    end
    chk_num(s, 2 * k + 9);
    chk_num(sd, 2 * k);
    for (n = 0; n < 500 && saw_valid !== 1'h1; n++) @(negedge clk);
    chk_vec(saw_valid, (^{dm, p}) != dp);
    chk_vec(32'(rx_word) & ((32'h1 << k) - 32'h1), dm);
    chk_vec(32'(rx_n), k);
    chk_vec({saw_cmd, saw_dat}, {sy, ~sy});
    chk_num(sync_len, k * BIT_TICKS * TICK);
    repeat (BIT_TICKS * TICK + 8) @(negedge clk);
  endtask
  task automatic chk_hunt();
    wait_for(3, 1'h0, 200);
    wait_for(3, 1'h1, 200);
    repeat (10) @(negedge clk);
    chk_vec(take_free, {~dsc});
    wait_for(3, 1'h0, 200);
    repeat (10) @(negedge clk);
    chk_vec(take_free, {~dsc});
  endtask
  task automatic abort_dec();
    start_enc(16, 1'h1, 32'h0000c6a5);
    wait_for(1, 1'h1, 800);
    dec_reset = 1'h1;
    repeat (80) @(negedge clk);
    dec_reset = 1'h0;
    chk_vec(take, 1'h0);
    repeat (1500) @(negedge clk);
    chk_vec(saw_valid, 1'h0);
  endtask
  task automatic abort_enc();
    start_enc(28, 1'h0, 32'h0f0f0f0f);
    repeat (300) @(negedge clk);
    mreset = 1'h1;
    repeat (20) @(negedge clk);
    mreset = 1'h0;
    repeat (150) @(negedge clk);
    chk_vec({one_n, zero_n, send_data, take, valid}, 5'h18);
  endtask
  task automatic inhibit();
    inhibit_n = 1'h0;
    start_enc(4, 1'h1, 32'h9);
    repeat (8) begin
      repeat (36) @(negedge clk);
      chk_vec({one_n, zero_n}, 2'h3);
    end
    repeat (200) @(negedge clk);
    inhibit_n = 1'h1;
    chk_vec({saw_cmd, saw_dat}, 2'h0);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    chk_vec({one_n, zero_n, send_data, take, cmd, dat, valid}, 7'h60);
    rst = 1'h0;
    chk_period(2, 6 * TICK);
    chk_period(3, BIT_TICKS * TICK);
    chk_period(4, BIT_TICKS * TICK);
    chk_hunt();
    send_word(2, 1'h1, 1'h1, 1'h0, 32'h2);
    send_word(28, 1'h0, 1'h0, 1'h1, 32'h0a5c3e71);
    trans_sel = 1'h1;
    send_word(16, 1'h1, 1'h1, 1'h0, 32'h0000b39d);
    uni_mode = 1'h1;
    send_word(9, 1'h0, 1'h0, 1'h1, 32'h0000016b);
    uni_mode = 1'h0;
    trans_sel = 1'h0;
    send_word(5, 1'h1, 1'h1, 1'h1, 32'h13);
    abort_dec();
    abort_enc();
    send_word(7, 1'h0, 1'h0, 1'h1, 32'h5a);
    inhibit();
    send_word(3, 1'h1, 1'h1, 1'h0, 32'h5);
    tally_and_finish();
  end
endmodule
